// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import pmc_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, exec = 1'b0, operand = 1'b0, ds_set = 1'b0;
    logic low_power_regulator_config = 1'b1, retention_regulator_enable = 1'b0, wdt_en = 1'b0, fail_safe_clock_monitor_en = 1'b0, real_time_calendar_en = 1'b0;
    logic real_time_calendar_low_power_rc_clock = 1'b0, supply_ok = 1'b1, wdt_clr, ds_en, rv, rn;
    logic [1:0] clk_src = 2'h0, src_out;
    logic [3:0] lag = 4'h0;
    logic [2:0] mode;
    wake_t req = '0, wake;
    pwr_t pwr;
    int n_fail = 0, checked = 0;

    // Free-running 50 MHz clock
    always #10 clk_in = ~clk_in;

    power_mode_controller uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .power_save_instruction_exec_in(exec),
        .power_save_instruction_operand_in(operand), .deep_sleep_enable_set_in(ds_set),
        .low_power_regulator_config_in(low_power_regulator_config), .retention_regulator_enable_in(retention_regulator_enable),
        .wdt_enable_in(wdt_en), .fail_safe_clock_monitor_enable_in(fail_safe_clock_monitor_en), .real_time_calendar_enable_in(real_time_calendar_en),
        .real_time_calendar_on_low_power_rc_clock_in(real_time_calendar_low_power_rc_clock), .clk_source_in(clk_src), .main_supply_ok_in(supply_ok),
        .wake_in(wake), .pwr_out(pwr), .wdt_clear_out(wdt_clr), .deep_sleep_enable_out(ds_en),
        .clk_source_out(src_out), .resume_reset_vector_out(rv), .resume_next_out(rn),
        .mode_out(mode)
    );
    wake_source_model partner (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .lag_in(lag), .wake_out(wake)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
            n_fail++;
        end
    endtask

    // Bounded wait; running out means the mode never came
    task automatic wait_mode(input logic [2:0] m);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_in);
            #1;
            if (mode === m) return;
        end
        n_fail++;
        end_sim();
    endtask

    // One-cycle power-save pulse; returns just after the edge that samples it
    task automatic save(input logic op);
        @(posedge clk_in);
        exec <= 1'b1;
        operand <= op;
        @(posedge clk_in);
        exec <= 1'b0;
        #1;
    endtask

    task automatic fire(input logic [7:0] w, input logic [3:0] l);
        @(posedge clk_in);
        req <= wake_t'(w);
        lag <= l;
        @(posedge clk_in);
        req <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Idle once with the watchdog and once with the clock monitor on the RC clock, woken slowly by an interrupt
    task automatic t_idle();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_in);
            wdt_en <= (k == 0);
            fail_safe_clock_monitor_en <= (k == 1);
            save(OPERAND_IDLE);
            chk(mode, 3'h1);
            chk({pwr.cpu_clk_en, pwr.sys_clk_en, pwr.periph_clk_en}, 3'h3);
            chk(wdt_clr, 1'b1);
            chk(pwr.low_power_rc_clock_en, 1'b1);
            fire(8'h80, 4'h5);
            wait_mode(3'h0);
            chk({rn, rv, pwr.cpu_clk_en}, 3'h5);
        end
    endtask

    // Plain sleep: config bit unprogrammed, so no retention despite the firmware bit
    task automatic t_sleep();
        @(posedge clk_in);
        clk_src <= 2'h2;
        wdt_en <= 1'b1;
        fail_safe_clock_monitor_en <= 1'b1;
        retention_regulator_enable <= 1'b1;
        save(OPERAND_SLEEP);
        chk(mode, 3'h2);
        chk({pwr.sys_clk_en, pwr.osc_en}, 2'h0);
        chk(pwr.io_freeze, 1'b1);
        chk({pwr.fail_safe_clock_monitor_en, pwr.periph_clk_en}, 2'h0);
        chk({pwr.low_power_rc_clock_en, wdt_clr, pwr.retention_on}, 3'h6);
        @(posedge clk_in);
        clk_src <= 2'h1;
        fire(8'h20, 4'h3);
        wait_mode(3'h0);
        chk({rn, src_out}, 3'h6);
    endtask

    // Low-voltage sleep with the calendar on the RC clock and no watchdog
    task automatic t_lv();
        @(posedge clk_in);
        low_power_regulator_config <= 1'b0;
        wdt_en <= 1'b0;
        fail_safe_clock_monitor_en <= 1'b0;
        real_time_calendar_en <= 1'b1;
        real_time_calendar_low_power_rc_clock <= 1'b1;
        #1;
        chk(pwr.retention_on, 1'b0);
        save(OPERAND_SLEEP);
        chk({mode, pwr.retention_on}, 4'h7);
        chk({pwr.low_power_rc_clock_en, wdt_clr}, 2'h2);
        fire(8'h40, 4'h0);
        wait_mode(3'h0);
        chk({rv, rn}, 2'h2);
    endtask

    // Armed deep sleep, then an armed-but-unused enable that must lapse
    task automatic t_deep();
        @(posedge clk_in);
        ds_set <= 1'b1; // Control bit 0 is never set by this bench
        // Instruction sampled on the very next edge, inside the one-cycle window
        @(posedge clk_in);
        ds_set <= 1'b0;
        exec <= 1'b1;
        operand <= OPERAND_SLEEP;
        @(posedge clk_in);
        exec <= 1'b0;
        #1;
        chk({mode, pwr.flash_pwr, pwr.io_freeze, pwr.periph_clk_en, ds_en}, 7'h45);
        chk({pwr.sram_pwr, pwr.low_power_rc_clock_en, pwr.retention_on, pwr.cpu_clk_en, pwr.sys_clk_en,
             pwr.osc_en}, 6'h38);
        fire(8'h01, 4'h2);
        wait_mode(3'h6);
        @(posedge clk_in);
        #1;
        chk({mode, rv, ds_en, src_out}, 7'h08);
        @(posedge clk_in);
        low_power_regulator_config <= 1'b1;
        ds_set <= 1'b1;
        @(posedge clk_in);
        ds_set <= 1'b0;
        #1;
        chk(ds_en, 1'b1);
        repeat (2) @(posedge clk_in);
        #1;
        chk(ds_en, 1'b0);
        save(OPERAND_SLEEP);
        chk(mode, 3'h2);
        fire(8'h80, 4'h0);
        wait_mode(3'h0);
    endtask

    // Interrupt lands on the same edge as the instruction, then supply loss
    task automatic t_edge_cases();
        fire(8'h80, 4'h0);
        save(OPERAND_IDLE);
        chk(mode, 3'h1);
        @(posedge clk_in);
        #1;
        chk({mode, rn}, 4'h1);
        @(posedge clk_in);
        supply_ok <= 1'b0;
        @(posedge clk_in);
        #1;
        chk(mode, 3'h5);
        fire(8'h81, 4'h0);
        repeat (4) @(posedge clk_in);
        supply_ok <= 1'b1;
        #1;
        chk(mode, 3'h5);
        wait_mode(3'h6);
        wait_mode(3'h0);
        chk(rv, 1'b1);
    endtask

    // Reset lands in mid-sleep: every output drops, then run values return
    task automatic t_reset();
        save(OPERAND_SLEEP);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        #1;
        chk(pwr, 10'h000);
        chk({mode, rv, rn, wdt_clr, ds_en, src_out}, 9'h000);
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk({pwr.cpu_clk_en, pwr.sys_clk_en, pwr.io_freeze, mode}, 6'h30);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset for 20 cycles, then every scenario in turn
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk({pwr.cpu_clk_en, pwr.sys_clk_en, pwr.flash_pwr, pwr.io_freeze, pwr.retention_on,
             mode}, 8'hE0);
        t_idle();
        t_sleep();
        t_lv();
        t_deep();
        t_edge_cases();
        t_reset();
        end_sim();
    end
endmodule

// ==== bench/wake_source_model.sv ====
`timescale 1ns/1ns
// Wake sources: a request fires once, as a one-cycle pulse, after lag cycles
module wake_source_model
    import pmc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire wake_t req_in,
    input wire logic [3:0] lag_in,
    output wake_t wake_out
);
    wake_t pend_q;
    logic [3:0] cnt_q;
    // Lag lets a scenario be answered promptly or slowly; the pulse never lingers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= '0;
            cnt_q <= 4'h0;
            wake_out <= '0;
        end else begin
            wake_out <= '0;
            if (req_in != '0) begin
                pend_q <= req_in;
                cnt_q <= lag_in;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (pend_q != '0) begin
                wake_out <= pend_q;
                pend_q <= '0;
            end
        end
    end
endmodule

// ==== hw/pmc_pkg.sv ====
package pmc_pkg;
    // Power-save instruction operands
    localparam logic OPERAND_SLEEP = 1'h0;
    localparam logic OPERAND_IDLE = 1'h1;
    // Window after deep-sleep enable during which the sleep form must follow
    localparam int DS_ARM_CYCLES = 1;
    // Reset value of the clock-source select that the block drives
    localparam logic [1:0] CLKSEL_RESET = 2'h0;

    typedef enum {
        ST_RUN,
        ST_IDLE,
        ST_SLEEP,
        ST_DEEP,
        ST_BATTERY,
        ST_WAKE_RESET
    } mode_t;

    // Wake causes gathered together
    typedef struct packed {
        logic irq;          // Any individually enabled interrupt
        logic reset;        // Any device reset
        logic wdt_timeout;  // Watchdog time-out
        logic alarm;        // Real-time calendar alarm
        logic ext_int_zero; // External interrupt zero
        logic ds_wdt;       // Deep-sleep watchdog time-out
        logic master_clear_pin;         // Master clear pin asserted
        logic por;          // Power-on reset
    } wake_t;

    // Power controls driven out
    typedef struct packed {
        logic cpu_clk_en;
        logic sys_clk_en;
        logic osc_en;
        logic periph_clk_en;
        logic io_freeze;
        logic fail_safe_clock_monitor_en;
        logic low_power_rc_clock_en;
        logic flash_pwr;
        logic sram_pwr;
        logic retention_on;
    } pwr_t;
endpackage

// ==== hw/power_mode_controller.sv ====
`timescale 1ns/1ns
module power_mode_controller
    import pmc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic power_save_instruction_exec_in,
    input wire logic power_save_instruction_operand_in,
    input wire logic deep_sleep_enable_set_in,
    input wire logic low_power_regulator_config_in,
    input wire logic retention_regulator_enable_in,
    input wire logic wdt_enable_in,
    input wire logic fail_safe_clock_monitor_enable_in,
    input wire logic real_time_calendar_enable_in,
    input wire logic real_time_calendar_on_low_power_rc_clock_in,
    input wire logic [1:0] clk_source_in,
    input wire logic main_supply_ok_in,
    input wire wake_t wake_in,
    output pwr_t pwr_out,
    output logic wdt_clear_out,
    output logic deep_sleep_enable_out,
    output logic [1:0] clk_source_out,
    output logic resume_reset_vector_out,
    output logic resume_next_out,
    output logic [2:0] mode_out
);
    ////////////////////////////////////////////////////////////////////////
    // State
    mode_t mode_q, mode_d;
    logic deep_sleep_enable_q, deep_sleep_enable_d;
    logic ds_arm_q, ds_arm_d;
    logic irq_hold_q, irq_hold_d;
    logic [1:0] clksel_q, clksel_d;
    pwr_t pwr_q, pwr_d;
    logic wdt_clr_q, wdt_clr_d;
    logic rv_q, rv_d;
    logic nx_q, nx_d;
    logic [2:0] mode_code_q, mode_code_d;
    logic ret_ok;
    logic light_wake;
    logic deep_wake;

    // Retention allowed only with config programmed and firmware bit set
    assign ret_ok = ~low_power_regulator_config_in & retention_regulator_enable_in;
    assign light_wake = wake_in.irq | wake_in.reset | wake_in.wdt_timeout
        | wake_in.por | wake_in.master_clear_pin | wake_in.alarm | wake_in.ext_int_zero;
    assign deep_wake = wake_in.por | wake_in.master_clear_pin | wake_in.alarm
        | wake_in.ext_int_zero | wake_in.ds_wdt;

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencing
    always_comb begin
        mode_d = mode_q;
        deep_sleep_enable_d = deep_sleep_enable_q;
        ds_arm_d = 1'b0;
        irq_hold_d = 1'b0;
        clksel_d = clksel_q;
        wdt_clr_d = 1'b0;
        rv_d = 1'b0;
        nx_d = 1'b0;
        // Enable window lasts one cycle; a late instruction finds it cleared
        if (deep_sleep_enable_set_in) begin
            deep_sleep_enable_d = 1'b1;
            ds_arm_d = 1'b1;
        end else if (deep_sleep_enable_q && !ds_arm_q && mode_q == ST_RUN) begin
            deep_sleep_enable_d = 1'b0;
        end
        if (!main_supply_ok_in && mode_q != ST_BATTERY) begin
            mode_d = ST_BATTERY;
        end else begin
            unique case (mode_q)
                ST_RUN: begin
                    if (power_save_instruction_exec_in) begin
                        // Coincident interrupt wakes idle or sleep only after entry completes; deep sleep ignores it
                        irq_hold_d = wake_in.irq;
                        if (power_save_instruction_operand_in == OPERAND_IDLE) begin
                            mode_d = ST_IDLE;
                            wdt_clr_d = 1'b1;
                        end else if (deep_sleep_enable_q && ds_arm_q) begin
                            mode_d = ST_DEEP;
                        end else begin
                            mode_d = ST_SLEEP;
                            clksel_d = clk_source_in;
                            wdt_clr_d = wdt_enable_in;
                        end
                    end
                end
                ST_IDLE, ST_SLEEP: begin
                    if (light_wake || irq_hold_q) begin
                        mode_d = ST_RUN;
                        nx_d = ~(wake_in.reset | wake_in.por | wake_in.master_clear_pin);
                        rv_d = wake_in.reset | wake_in.por | wake_in.master_clear_pin;
                    end
                end
                ST_DEEP: begin
                    if (deep_wake) begin
                        mode_d = ST_WAKE_RESET;
                        deep_sleep_enable_d = 1'b0;
                    end
                end
                ST_BATTERY: begin
                    if (main_supply_ok_in) begin
                        mode_d = ST_WAKE_RESET;
                    end
                end
                ST_WAKE_RESET: begin
                    mode_d = ST_RUN;
                    rv_d = 1'b1;
                    clksel_d = CLKSEL_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power controls decoded from the next mode
    always_comb begin
        pwr_d = '0;
        mode_code_d = 3'h0;
        unique case (mode_d)
            ST_RUN: begin
                pwr_d.cpu_clk_en = 1'b1;
                pwr_d.sys_clk_en = 1'b1;
                pwr_d.osc_en = 1'b1;
                pwr_d.periph_clk_en = 1'b1;
                pwr_d.fail_safe_clock_monitor_en = fail_safe_clock_monitor_enable_in;
                pwr_d.low_power_rc_clock_en = wdt_enable_in | fail_safe_clock_monitor_enable_in | real_time_calendar_on_low_power_rc_clock_in;
                pwr_d.flash_pwr = 1'b1;
                pwr_d.sram_pwr = 1'b1;
            end
            ST_IDLE: begin
                // CPU stopped; system clock keeps peripherals alive
                pwr_d.sys_clk_en = 1'b1;
                pwr_d.osc_en = 1'b1;
                pwr_d.periph_clk_en = 1'b1;
                pwr_d.fail_safe_clock_monitor_en = fail_safe_clock_monitor_enable_in;
                pwr_d.low_power_rc_clock_en = wdt_enable_in | fail_safe_clock_monitor_enable_in;
                pwr_d.flash_pwr = 1'b1;
                pwr_d.sram_pwr = 1'b1;
                mode_code_d = 3'h1;
            end
            ST_SLEEP: begin
                // Clock source, oscillator and monitor all off
                pwr_d.io_freeze = 1'b1;
                pwr_d.low_power_rc_clock_en = wdt_enable_in | (real_time_calendar_enable_in & real_time_calendar_on_low_power_rc_clock_in);
                pwr_d.flash_pwr = 1'b1;
                pwr_d.sram_pwr = 1'b1;
                pwr_d.retention_on = ret_ok;
                mode_code_d = ret_ok ? 3'h3 : 3'h2;
            end
            ST_DEEP: begin
                // Only calendar and deep watchdog remain; SRAM kept only on retention
                pwr_d.io_freeze = 1'b1;
                pwr_d.low_power_rc_clock_en = real_time_calendar_enable_in & real_time_calendar_on_low_power_rc_clock_in;
                pwr_d.sram_pwr = ret_ok;
                pwr_d.retention_on = ret_ok;
                mode_code_d = 3'h4;
            end
            ST_BATTERY: begin
                pwr_d.io_freeze = 1'b1;
                mode_code_d = 3'h5;
            end
            ST_WAKE_RESET: begin
                pwr_d.io_freeze = 1'b1;
                mode_code_d = 3'h6;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q <= ST_RUN;
            deep_sleep_enable_q <= 1'b0;
            ds_arm_q <= 1'b0;
            irq_hold_q <= 1'b0;
            clksel_q <= CLKSEL_RESET;
            pwr_q <= '0;
            wdt_clr_q <= 1'b0;
            rv_q <= 1'b0;
            nx_q <= 1'b0;
            mode_code_q <= 3'h0;
        end else begin
            mode_q <= mode_d;
            deep_sleep_enable_q <= deep_sleep_enable_d;
            ds_arm_q <= ds_arm_d;
            irq_hold_q <= irq_hold_d;
            clksel_q <= clksel_d;
            pwr_q <= pwr_d;
            wdt_clr_q <= wdt_clr_d;
            rv_q <= rv_d;
            nx_q <= nx_d;
            mode_code_q <= mode_code_d;
        end
    end

    assign pwr_out = pwr_q;
    assign wdt_clear_out = wdt_clr_q;
    assign deep_sleep_enable_out = deep_sleep_enable_q;
    assign clk_source_out = clksel_q;
    assign resume_reset_vector_out = rv_q;
    assign resume_next_out = nx_q;
    assign mode_out = mode_code_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_idle_clock;
        @(posedge clk_in) disable iff (!rst_n_in)
        mode_code_q == 3'h1 |-> pwr_q.sys_clk_en && !pwr_q.cpu_clk_en;
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("idle clocks wrong");

    property p_sleep_off;
        @(posedge clk_in) disable iff (!rst_n_in)
        (mode_code_q == 3'h2) |-> !pwr_q.osc_en && !pwr_q.fail_safe_clock_monitor_en && pwr_q.io_freeze;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep controls wrong");

    property p_ret;
        @(posedge clk_in) disable iff (!rst_n_in)
        pwr_q.retention_on |-> mode_code_q inside {3'h3, 3'h4};
    endproperty
    a_ret: assert property (p_ret) else $error("retention outside sleep");

    property p_idle_wdt;
        @(posedge clk_in) disable iff (!rst_n_in)
        (mode_q == ST_RUN && power_save_instruction_exec_in && power_save_instruction_operand_in && main_supply_ok_in)
            |=> wdt_clr_q && mode_code_q == 3'h1;
    endproperty
    a_idle_wdt: assert property (p_idle_wdt) else $error("idle entry wrong");

    property p_defer;
        @(posedge clk_in) disable iff (!rst_n_in)
        (mode_q == ST_RUN && power_save_instruction_exec_in && wake_in.irq && main_supply_ok_in
            && !(power_save_instruction_operand_in == OPERAND_SLEEP && deep_sleep_enable_q && ds_arm_q))
            |=> mode_q != ST_RUN ##1 (mode_q == ST_RUN || !main_supply_ok_in);
    endproperty
    a_defer: assert property (p_defer) else $error("deferred wake missing");

    property p_deep_sleep_enable_drop;
        @(posedge clk_in) disable iff (!rst_n_in)
        (deep_sleep_enable_q && !ds_arm_q && mode_q == ST_RUN && !deep_sleep_enable_set_in)
            |=> !deep_sleep_enable_q;
    endproperty
    a_deep_sleep_enable_drop: assert property (p_deep_sleep_enable_drop) else $error("enable not cleared");

    property p_battery;
        @(posedge clk_in) disable iff (!rst_n_in)
        !main_supply_ok_in |=> mode_q == ST_BATTERY;
    endproperty
    a_battery: assert property (p_battery) else $error("battery not entered");

    property p_deep_rv;
        @(posedge clk_in) disable iff (!rst_n_in)
        mode_q == ST_WAKE_RESET && main_supply_ok_in |=> rv_q && mode_q == ST_RUN;
    endproperty
    a_deep_rv: assert property (p_deep_rv) else $error("reset vector missing");

    // Sleep entry captures the clock choice and clears the watchdog only if enabled
    property p_sleep_entry;
        @(posedge clk_in) disable iff (!rst_n_in)
        (mode_q == ST_RUN && power_save_instruction_exec_in && power_save_instruction_operand_in == OPERAND_SLEEP
            && !(deep_sleep_enable_q && ds_arm_q) && main_supply_ok_in)
            |=> mode_q == ST_SLEEP && wdt_clr_q == $past(wdt_enable_in)
            && clksel_q == $past(clk_source_in);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

    property p_deep_off;
        @(posedge clk_in) disable iff (!rst_n_in)
        mode_code_q == 3'h4 |-> !pwr_q.flash_pwr && !pwr_q.cpu_clk_en && !pwr_q.osc_en
            && !pwr_q.periph_clk_en && pwr_q.io_freeze;
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("deep sleep controls wrong");

    // Controls are registered, so the enables are those of the previous edge
    property p_ret_cfg;
        @(posedge clk_in) disable iff (!rst_n_in)
        pwr_q.retention_on |-> $past(ret_ok);
    endproperty
    a_ret_cfg: assert property (p_ret_cfg) else $error("retention without enables");

    property p_idle_low_power_rc_clock;
        @(posedge clk_in) disable iff (!rst_n_in)
        mode_code_q == 3'h1 |-> pwr_q.low_power_rc_clock_en == $past(wdt_enable_in | fail_safe_clock_monitor_enable_in);
    endproperty
    a_idle_low_power_rc_clock: assert property (p_idle_low_power_rc_clock) else $error("idle RC clock wrong");

    c_idle: cover property (@(posedge clk_in) mode_q == ST_IDLE ##1 mode_q == ST_RUN);
    c_sleep: cover property (@(posedge clk_in) mode_code_q == 3'h3);
    c_deep: cover property (@(posedge clk_in) mode_q == ST_DEEP ##1 mode_q == ST_WAKE_RESET);
    c_batt: cover property (@(posedge clk_in) mode_q == ST_BATTERY);
endmodule
